// [rtl/fsl_fan_logic.sv]
// Fan speed mode logic: settings, level mapping, start, commands, LEDs
`timescale 1ns/1ns
`default_nettype none
module fsl_fan_logic
    import fsl_pkg::*;
#(
    parameter int PULSE_CYC = fsl_pkg::PULSE_MIN_CYC,
    parameter int BLINK_CYC = fsl_pkg::BLINK_HALF_CYC,
    parameter int KICK_LEN  = fsl_pkg::KICK_CYC,
    parameter int STEP_CYC  = fsl_pkg::SOFT_STEP_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Mode selection
    input  wire logic       modbus_mode,
    input  wire logic       descending_mode,
    input  wire logic       timer_mode,
    input  wire logic       logic_mode,
    input  wire logic       modbus_frame_seen,
    // Local settings
    input  wire logic [7:0] local_upper,
    input  wire logic [7:0] local_lower,
    input  wire logic [7:0] local_off_value,
    input  wire logic       local_kick,
    input  wire logic       local_off_en,
    // Field inputs
    input  wire logic [7:0] analogue_input_terminal,
    input  wire logic       remote_switch_input,
    // Outputs
    output logic      [7:0] motor_level,
    output logic            motor_on,
    output logic            green_led,
    output logic            red_led,
    output logic            irq
);
    import fsl_pkg::*;

    if (PULSE_CYC < 1 || BLINK_CYC < 2 || KICK_LEN < 1 || STEP_CYC < 1) begin : g_bad
        $error("fsl_fan_logic: timing parameters out of range");
    end

    // Software visible state
    logic [1:0] ctrl;
    logic [7:0] reg_upper;
    logic [7:0] reg_lower;
    logic [7:0] reg_off_value;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;

    // Operating state
    fsl_start_e        st;
    fsl_start_e        next_st;
    logic [7:0]        level;
    logic              cmd_on;
    logic              started_once;
    logic              active_q;
    logic              in_off_q;
    logic              net_seen;
    logic [4:0]        net_toggles;
    logic              blink;
    logic [$clog2(KICK_LEN+1)-1:0] kick_cnt;

    // Register decode
    wire wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
    wire wr_upper = reg_wr && (reg_addr == REG_UPPER);
    wire wr_lower = reg_wr && (reg_addr == REG_LOWER);
    wire wr_off   = reg_wr && (reg_addr == REG_OFF_VALUE);
    wire wr_stat  = reg_wr && (reg_addr == REG_IRQ_STAT);
    wire wr_mask  = reg_wr && (reg_addr == REG_IRQ_MASK);

    // Source select between registers and local controls
    wire [7:0] sel_upper = modbus_mode ? reg_upper : local_upper;
    wire [7:0] sel_lower = modbus_mode ? reg_lower : local_lower;
    wire [7:0] sel_off_v = modbus_mode ? reg_off_value : local_off_value;
    wire       sel_kick  = modbus_mode ? ctrl[CTRL_KICK] : local_kick;
    wire       sel_off   = modbus_mode ? ctrl[CTRL_OFF_EN] : local_off_en;

    // Limits held inside their legal windows, whatever the source says
    wire [7:0] lim_lo = (sel_lower < LOWER_MIN) ? LOWER_MIN :
                        (sel_lower > LOWER_MAX) ? LOWER_MAX : sel_lower;
    wire [7:0] lim_hi = (sel_upper < UPPER_MIN) ? UPPER_MIN :
                        (sel_upper > UPPER_MAX) ? UPPER_MAX : sel_upper;

    // Input clipped at full scale so the mapping never overshoots
    wire [7:0]  ain    = (analogue_input_terminal > FULL_SCALE) ?
                         FULL_SCALE : analogue_input_terminal;
    wire [7:0]  span   = lim_hi - lim_lo;
    wire [15:0] prod   = span * ain;
    wire [7:0]  delta  = 8'(prod / 16'(FULL_SCALE));
    wire [7:0]  mapped = descending_mode ? lim_hi - delta
                                         : lim_lo + delta;

    // Off zone: below the off value in signal sense, and the end points
    wire off_asc  = (ain < sel_off_v) || (ain == 8'h00);
    wire off_desc = (ain > sel_off_v) || (ain == FULL_SCALE);
    wire in_off   = sel_off && (descending_mode ? off_desc : off_asc);
    wire at_off_v = sel_off && (ain == sel_off_v) && !in_off;
    wire [7:0] target = at_off_v ? (descending_mode ? lim_hi : lim_lo)
                                 : mapped;

    // Command source and remote control mode
    wire remote_mode = timer_mode || logic_mode;
    wire ai_logic    = (analogue_input_terminal >= LOGIC_THRESH);
    wire cmd_level   = logic_mode ? ai_logic
                                  : remote_switch_input;
    wire cmd_pulse;

    // One filter serves both sources; only one is selected at a time
    fsl_pulse_filter #(
        .MIN_CYC (PULSE_CYC)
    ) u_filter (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .level_in (cmd_level && remote_mode),
        .accepted (cmd_pulse)
    );

    wire blink_tick;
    wire step_tick;

    // Blink half period from the system clock
    fsl_tick #(
        .PERIOD (BLINK_CYC)
    ) u_blink (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .restart  (1'b0),
        .tick     (blink_tick)
    );

    // Soft start step pacing, realigned at each start
    fsl_tick #(
        .PERIOD (STEP_CYC)
    ) u_step (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .restart  (st == FSL_IDLE),
        .tick     (step_tick)
    );

    // Output demand and start decision
    wire want_run   = (remote_mode ? cmd_on : 1'b1) && !in_off;
    wire switch_on  = want_run && !active_q;
    wire need_start = sel_off || !started_once;
    wire kick_done  = (kick_cnt == '0);
    wire soft_done  = (level >= target);

    // Start sequencer transitions
    always_comb begin
        next_st = st;
        unique case (st)
            FSL_IDLE: begin
                if (want_run) begin
                    if (!need_start) begin
                        next_st = FSL_RUN;
                    end else if (sel_kick) begin
                        next_st = FSL_KICK;
                    end else begin
                        next_st = FSL_SOFT;
                    end
                end
            end
            FSL_KICK: begin
                if (!want_run) begin
                    next_st = FSL_IDLE;
                end else if (kick_done) begin
                    next_st = FSL_RUN;
                end
            end
            FSL_SOFT: begin
                if (!want_run) begin
                    next_st = FSL_IDLE;
                end else if (soft_done) begin
                    next_st = FSL_RUN;
                end
            end
            FSL_RUN: begin
                if (!want_run) begin
                    next_st = FSL_IDLE;
                end
            end
        endcase
    end

    wire start_done = ((st == FSL_KICK) || (st == FSL_SOFT)) && (next_st == FSL_RUN);

    // Level the motor sees in each state; kick runs at the upper limit
    wire [7:0] next_level =
        (next_st == FSL_IDLE) ? 8'h00 :
        (next_st == FSL_KICK) ? lim_hi :
        (next_st == FSL_RUN)  ? target :
        (st != FSL_SOFT)      ? lim_lo :
        (step_tick && level < target) ? level + 8'h01 : level;

    // Sequencer, level and start history
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st           <= FSL_IDLE;
            level        <= 8'h00;
            started_once <= 1'b0;
            active_q     <= 1'b0;
            kick_cnt     <= '0;
        end else if (clk_en) begin
            st       <= next_st;
            level    <= next_level;
            active_q <= want_run;
            if (start_done || (st == FSL_IDLE && next_st == FSL_RUN)) begin
                started_once <= 1'b1;
            end
            if (switch_on) begin
                kick_cnt <= ($clog2(KICK_LEN + 1))'(KICK_LEN - 1);
            end else if (!kick_done) begin
                kick_cnt <= kick_cnt - 1'b1;
            end
        end
    end

    // Remote on/off: each accepted pulse toggles the demand
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cmd_on <= 1'b0;
        end else if (clk_en) begin
            if (!remote_mode) begin
                cmd_on <= 1'b0;
            end else if (cmd_pulse) begin
                cmd_on <= !cmd_on;
            end
        end
    end

    // Network detection starts a fixed burst of blinks on both LEDs
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            net_seen    <= 1'b0;
            net_toggles <= 5'h00;
        end else if (clk_en) begin
            if (modbus_frame_seen && !net_seen) begin
                net_seen    <= 1'b1;
                net_toggles <= 5'(2 * NET_BLINKS);
            end else if (blink_tick && net_toggles != 5'h00) begin
                net_toggles <= net_toggles - 5'h01;
            end
        end
    end

    wire net_ident = (net_toggles != 5'h00);

    // LED drive; network burst overrides the status pattern
    wire next_green = net_ident              ? blink :
                      remote_mode            ? blink :
                      in_off                 ? blink :
                                               1'b1;
    wire next_red   = net_ident && blink;

    // Registered outputs
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            blink       <= 1'b0;
            green_led   <= 1'b0;
            red_led     <= 1'b0;
            motor_level <= 8'h00;
            motor_on    <= 1'b0;
            in_off_q    <= 1'b0;
        end else if (clk_en) begin
            if (blink_tick) begin
                blink <= !blink;
            end
            green_led   <= next_green;
            red_led     <= next_red;
            motor_level <= next_level;
            motor_on    <= (next_st != FSL_IDLE);
            in_off_q    <= in_off;
        end
    end

    // Events; a new event wins over a clear in the same cycle
    wire [2:0] events;
    assign events[IRQ_CMD]        = cmd_pulse;
    assign events[IRQ_START_DONE] = start_done;
    assign events[IRQ_OFF_ENTER]  = in_off && !in_off_q;

    // Setting and interrupt registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl          <= RST_CTRL;
            reg_upper     <= RST_UPPER;
            reg_lower     <= RST_LOWER;
            reg_off_value <= RST_OFF_VALUE;
            irq_stat      <= 3'h0;
            irq_mask      <= 3'h0;
            irq           <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata[1:0];
            end
            if (wr_upper) begin
                reg_upper <= reg_wdata;
            end
            if (wr_lower) begin
                reg_lower <= reg_wdata;
            end
            if (wr_off) begin
                reg_off_value <= reg_wdata;
            end
            if (wr_mask) begin
                irq_mask <= reg_wdata[2:0];
            end
            irq_stat <= (irq_stat & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | events;
            irq      <= |(((irq_stat & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | events)
                          & (wr_mask ? reg_wdata[2:0] : irq_mask));
        end
    end

    // Read mux; unmapped offsets read zero
    wire [7:0] state_word = {2'b00, net_seen, started_once, in_off,
                             cmd_on, st};
    wire [7:0] rd_mux =
        (reg_addr == REG_CTRL)      ? {6'h00, ctrl} :
        (reg_addr == REG_UPPER)     ? reg_upper :
        (reg_addr == REG_LOWER)     ? reg_lower :
        (reg_addr == REG_OFF_VALUE) ? reg_off_value :
        (reg_addr == REG_STATE)     ? state_word :
        (reg_addr == REG_LEVEL)     ? level :
        (reg_addr == REG_IRQ_STAT)  ? {5'h00, irq_stat} :
        (reg_addr == REG_IRQ_MASK)  ? {5'h00, irq_mask} : 8'h00;

    // Read data stands the cycle after the strobe only
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end
endmodule // fsl_fan_logic
`default_nettype wire

// [rtl/fsl_pkg.sv]
// Shared constants for the fan speed mode logic
package fsl_pkg;
    // Clock and timing
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          PULSE_MIN_MS   = 30;
    localparam int          PULSE_MIN_CYC  = (CLK_HZ / 1000) * PULSE_MIN_MS;
    localparam int          BLINK_HALF_MS  = 250;
    localparam int          BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int          KICK_MS        = 1000;
    localparam int          KICK_CYC       = (CLK_HZ / 1000) * KICK_MS;
    localparam int          SOFT_STEP_MS   = 20;
    localparam int          SOFT_STEP_CYC  = (CLK_HZ / 1000) * SOFT_STEP_MS;
    localparam int          NET_BLINKS     = 8;
    // Level codes, percent of supply or of full-scale input
    localparam logic [7:0]  FULL_SCALE     = 8'h64;
    localparam logic [7:0]  LOWER_MIN      = 8'h1e;
    localparam logic [7:0]  LOWER_MAX      = 8'h46;
    localparam logic [7:0]  UPPER_MIN      = 8'h4b;
    localparam logic [7:0]  UPPER_MAX      = 8'h64;
    localparam logic [7:0]  LOGIC_THRESH   = 8'h19;
    // Register offsets
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_UPPER      = 4'h1;
    localparam logic [3:0]  REG_LOWER      = 4'h2;
    localparam logic [3:0]  REG_OFF_VALUE  = 4'h3;
    localparam logic [3:0]  REG_STATE      = 4'h4;
    localparam logic [3:0]  REG_LEVEL      = 4'h5;
    localparam logic [3:0]  REG_IRQ_STAT   = 4'h6;
    localparam logic [3:0]  REG_IRQ_MASK   = 4'h7;
    // Control register fields
    localparam int          CTRL_KICK      = 0;
    localparam int          CTRL_OFF_EN    = 1;
    // Interrupt bits
    localparam int          IRQ_CMD        = 0;
    localparam int          IRQ_START_DONE = 1;
    localparam int          IRQ_OFF_ENTER  = 2;
    // Reset values
    localparam logic [7:0]  RST_UPPER      = 8'h64;
    localparam logic [7:0]  RST_LOWER      = 8'h1e;
    localparam logic [7:0]  RST_OFF_VALUE  = 8'h00;
    localparam logic [1:0]  RST_CTRL       = 2'h0;
    // Start sequencer states, Gray along idle-kick-soft-run
    typedef enum logic [1:0] {
        FSL_IDLE = 2'b00,
        FSL_KICK = 2'b01,
        FSL_SOFT = 2'b11,
        FSL_RUN  = 2'b10
    } fsl_start_e;
endpackage

// [rtl/fsl_pulse_filter.sv]
// Command pulse filter: passes only pulses longer than a minimum width
`timescale 1ns/1ns
`default_nettype none
module fsl_pulse_filter #(
    parameter int MIN_CYC = 3_000_000
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic level_in,
    output logic      accepted
);
    localparam int CW = $clog2(MIN_CYC + 2);

    logic [CW-1:0] run_cnt;
    logic          fired;
    wire           long_enough = (run_cnt == CW'(MIN_CYC));

    // Counts the high time; one pulse once the width exceeds the minimum
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            run_cnt  <= '0;
            fired    <= 1'b0;
            accepted <= 1'b0;
        end else if (clk_en) begin
            accepted <= level_in && long_enough && !fired;
            if (!level_in) begin
                run_cnt <= '0;
                fired   <= 1'b0;
            end else if (!long_enough) begin
                run_cnt <= run_cnt + CW'(1);
            end else begin
                fired <= 1'b1;
            end
        end
    end
endmodule // fsl_pulse_filter
`default_nettype wire

// [rtl/fsl_tick.sv]
// Periodic tick generator for blink and ramp timing
`timescale 1ns/1ns
`default_nettype none
module fsl_tick #(
    parameter int PERIOD = 25_000_000
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic restart,
    output logic      tick
);
    localparam int CW = $clog2(PERIOD + 1);

    logic [CW-1:0] cnt;
    wire           at_end = (cnt == CW'(PERIOD - 1));

    // Free running divider; restart realigns it to a fresh period
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (clk_en) begin
            tick <= at_end && !restart;
            cnt  <= (at_end || restart) ? '0 : cnt + CW'(1);
        end
    end
endmodule // fsl_tick
`default_nettype wire

// [verif/fsl_fan_checker.sv]
// Port-level assertions for the fan speed mode logic
`timescale 1ns/1ns
`default_nettype none
module fsl_fan_checker
    import fsl_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       modbus_mode,
    input wire logic       descending_mode,
    input wire logic       timer_mode,
    input wire logic       logic_mode,
    input wire logic       modbus_frame_seen,
    input wire logic       local_off_en,
    input wire logic [7:0] analogue_input_terminal,
    input wire logic [7:0] motor_level,
    input wire logic       motor_on,
    input wire logic       green_led,
    input wire logic       red_led,
    input wire logic       irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic net_seen;
    // Local normal running; off zone and remote modes excluded
    wire logic normal_local = clk_en && !modbus_mode && !timer_mode && !logic_mode
                              && !local_off_en && !net_seen;
    // Frame seen since reset, so red has a reason to light
    always_ff @(posedge core_clk) begin
        if (!reset_n)
            net_seen <= 1'b0;
        else if (modbus_frame_seen)
            net_seen <= 1'b1;
    end
    // Local off zone at the end points, held steady
    sequence s_asc_zero;
        clk_en && !modbus_mode && !timer_mode && !logic_mode && local_off_en
            && !descending_mode && analogue_input_terminal == 8'h00;
    endsequence
    sequence s_desc_full;
        clk_en && !modbus_mode && !timer_mode && !logic_mode && local_off_en
            && descending_mode && analogue_input_terminal >= FULL_SCALE;
    endsequence
    chk_read_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_unmapped_read: assert property (clk_en && reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    chk_enable_freeze: assert property (!clk_en |=> $stable(motor_level) && $stable(motor_on)
        && $stable(irq) && $stable(reg_rdata)) else $error("outputs moved while frozen");
    chk_stop_level: assert property (!motor_on && !$past(motor_on) |-> motor_level == 8'h00)
        else $error("level not zero while stopped");
    chk_run_limits: assert property (motor_on && $past(motor_on) |->
        motor_level inside {[LOWER_MIN:UPPER_MAX]}) else $error("level outside limits");
    chk_red_quiet: assert property (!net_seen |-> !red_led)
        else $error("red lit without network");
    chk_green_steady: assert property (normal_local [*3] |-> green_led)
        else $error("green not steady in normal mode");
    chk_mask_clears: assert property ((clk_en && reg_wr && reg_addr == REG_IRQ_MASK
        && reg_wdata == 8'h00) ##1 clk_en |=> !irq) else $error("irq high with mask clear");
    chk_asc_stop: assert property (s_asc_zero [*8] |-> !motor_on)
        else $error("motor runs at zero input, ascending");
    chk_desc_stop: assert property (s_desc_full [*8] |-> !motor_on)
        else $error("motor runs at full input, descending");
endmodule // fsl_fan_checker
bind fsl_fan_logic fsl_fan_checker fsl_fan_checker_inst (.*);
`default_nettype wire

// [verif/fsl_field_partner.sv]
// Model of the remote switch and of Modbus network activity
`timescale 1ns/1ns
`default_nettype none
module fsl_field_partner (
    input  wire logic core_clk,
    output logic      remote_switch_input,
    output logic      modbus_frame_seen
);
    // Open contact reads low through its pull-down
    initial begin
        remote_switch_input = 1'b0;
        modbus_frame_seen = 1'b0;
    end
    // Contact closed for a whole number of cycles
    task automatic press(input int cycles);
        @(posedge core_clk);
        remote_switch_input <= 1'b1;
        repeat (cycles) @(posedge core_clk);
        remote_switch_input <= 1'b0;
    endtask
    // One frame heard on the bus
    task automatic frame();
        @(posedge core_clk);
        modbus_frame_seen <= 1'b1;
        @(posedge core_clk);
        modbus_frame_seen <= 1'b0;
    endtask
endmodule // fsl_field_partner
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the fan speed mode logic
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fsl_pkg::*;
    logic       core_clk, reset_n, clk_en, reg_wr, reg_rd, rd_d, motor_on, green_led;
    logic       red_led, irq, modbus_mode, descending_mode, timer_mode, logic_mode;
    logic       local_kick, local_off_en, remote_switch_input, modbus_frame_seen;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, local_upper, local_lower, local_off_value;
    logic [7:0] analogue_input_terminal, motor_level, up_r, ai_v;
    logic [7:0] exp_q[$];
    int         n_fail, check_count, cyc, g_tog, r_tog;
    // Short counts keep the run brief
    fsl_fan_logic #(.PULSE_CYC(20), .BLINK_CYC(4), .KICK_LEN(10), .STEP_CYC(2))
        fsl_fan_logic_inst (.*);
    fsl_field_partner fsl_field_partner_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t read got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t pin got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe; hang guard
    always @(posedge core_clk) begin
        rd_d <= reg_rd && clk_en;
        if (rd_d)
            cmp_byte(reg_rdata, exp_q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Note the expectation first, the monitor takes it a cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // Counts LED changes; blinking shows as any change in the window
    task automatic watch(input int n);
        logic g, r;
        {g_tog, r_tog} = '0;
        {g, r} = {green_led, red_led};
        repeat (n) begin
            @(posedge core_clk);
            g_tog += int'(green_led !== g);
            r_tog += int'(red_led !== r);
            {g, r} = {green_led, red_led};
        end
    endtask
    function automatic logic [7:0] map_lvl(input logic [7:0] lo, hi, ai, input logic desc);
        int s;
        s = (int'(hi) - int'(lo)) * int'(ai) / 100;
        return desc ? 8'(int'(hi) - s) : 8'(int'(lo) + s);
    endfunction
    initial begin
        {reset_n, reg_wr, reg_rd, modbus_mode, descending_mode, timer_mode} = '0;
        {logic_mode, local_off_en, analogue_input_terminal} = '0;
        {clk_en, local_upper, local_lower} = {1'b1, 8'h5a, 8'h28};
        void'($urandom(1634));
        // Idle bus fields and the first start type are random from the outset
        {local_kick, reg_addr, reg_wdata, local_off_value} = 21'($urandom);
        tick(12);
        reset_n <= 1'b1;
        rd(REG_UPPER, RST_UPPER);
        rd(REG_LOWER, RST_LOWER);
        rd(REG_OFF_VALUE, RST_OFF_VALUE);
        rd(REG_CTRL, {6'h00, RST_CTRL});
        rd(4'hc, 8'h00);
        tick(400);
        // Both directions: the two ends and a random point between
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 3; k++) begin
                ai_v = (k == 2) ? 8'($urandom_range(99, 1)) : 8'(k * 100);
                descending_mode <= d[0];
                analogue_input_terminal <= ai_v;
                tick(10);
                rd(REG_LEVEL, map_lvl(8'h28, 8'h5a, ai_v, d[0]));
            end
        end
        {local_lower, local_upper} <= {8'h0a, 8'h32};
        {descending_mode, analogue_input_terminal} <= 9'h000;
        tick(10);
        rd(REG_LEVEL, LOWER_MIN);
        analogue_input_terminal <= 8'h64;
        tick(10);
        rd(REG_LEVEL, UPPER_MIN);
        // Register settings take over from the local controls
        up_r = 8'($urandom_range(100, 75));
        wr(REG_UPPER, up_r);
        wr(REG_LOWER, 8'h32);
        modbus_mode <= 1'b1;
        tick(10);
        rd(REG_UPPER, up_r);
        rd(REG_LEVEL, up_r);
        analogue_input_terminal <= 8'h00;
        tick(10);
        rd(REG_LEVEL, 8'h32);
        wr(REG_CTRL, 8'h02);
        tick(5);
        rd(REG_LEVEL, 8'h00);
        cmp_bit(motor_on, 1'b0);
        {modbus_mode, local_upper, local_lower} <= {1'b0, 8'h5a, 8'h28};
        // Off zone: stop, status bit, masking, blink, restart at the off value
        wr(REG_IRQ_MASK, 8'h04);
        wr(REG_IRQ_STAT, 8'h07);
        {local_kick, local_off_value, local_off_en} <= {1'($urandom), 8'h14, 1'b1};
        tick(10);
        rd(REG_LEVEL, 8'h00);
        rd(REG_IRQ_STAT, 8'h04);
        cmp_bit(irq, 1'b1);
        watch(20);
        cmp_bit(g_tog != 0, 1'b1);
        wr(REG_IRQ_MASK, 8'h00);
        tick(2);
        cmp_bit(irq, 1'b0);
        wr(REG_IRQ_STAT, 8'h07);
        analogue_input_terminal <= 8'h14;
        tick(400);
        rd(REG_LEVEL, 8'h28);
        cmp_byte(motor_level, 8'h28);
        rd(REG_IRQ_STAT, 8'h02);
        {local_off_value, descending_mode, analogue_input_terminal} <= {8'h50, 1'b1, 8'h64};
        tick(10);
        rd(REG_LEVEL, 8'h00);
        analogue_input_terminal <= 8'h50;
        tick(400);
        rd(REG_LEVEL, 8'h5a);
        {local_off_en, descending_mode, clk_en} <= 3'b000;
        tick(6);
        clk_en <= 1'b1;
        tick(2);
        watch(20);
        cmp_bit(g_tog == 0, 1'b1);
        // Remote switch: a pulse at the limit is noise, one cycle more counts
        wr(REG_IRQ_MASK, 8'h01);
        wr(REG_IRQ_STAT, 8'h07);
        timer_mode <= 1'b1;
        watch(20);
        cmp_bit(g_tog != 0, 1'b1);
        fsl_field_partner_inst.press(20);
        fsl_field_partner_inst.press(1 + $urandom_range(18));
        tick(5);
        cmp_bit(irq, 1'b0);
        fsl_field_partner_inst.press(21);
        tick(5);
        cmp_bit(irq, 1'b1);
        rd(REG_IRQ_STAT, 8'h01);
        wr(REG_IRQ_STAT, 8'h01);
        {timer_mode, logic_mode, analogue_input_terminal} <= {2'b01, 8'h00};
        tick(5);
        cmp_bit(irq, 1'b0);
        // Analogue input as logic level, 20 cycles refused, 21 taken
        for (int n = 20; n < 22; n++) begin
            analogue_input_terminal <= 8'($urandom_range(100, 25));
            tick(n);
            analogue_input_terminal <= 8'h00;
            tick(5);
            cmp_bit(irq, n[0]);
        end
        logic_mode <= 1'b0;
        fsl_field_partner_inst.frame();
        watch(30);
        cmp_bit(r_tog != 0, 1'b1);
        tick(3);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
